// ===== rtl/ssdl_pkg.sv
// ssdl_pkg: constants and types for the starter diagnostic status logic.
// assumes a single 10 MHz system clock shared with the gateway-side logic.
`default_nettype none

package ssdl_pkg;

   // ------------------------------------------------------------------
   // clock and timing
   // ------------------------------------------------------------------
   localparam int CLK_HZ         = 10_000_000;
   localparam int SW_TIMEOUT_MS  = 4000;
   localparam int SW_TIMEOUT_CYC = CLK_HZ / 1000 * SW_TIMEOUT_MS;
   localparam int FLASH_SLOW_HZ  = 1;
   localparam int FLASH_FAST_HZ  = 3;
   localparam int SLOW_HALF_CYC  = CLK_HZ / (2 * FLASH_SLOW_HZ);
   localparam int FAST_HALF_CYC  = CLK_HZ / (2 * FLASH_FAST_HZ);
   localparam int CNT_W          = 26;

   // ------------------------------------------------------------------
   // advanced diagnostic codes
   // ------------------------------------------------------------------
   localparam logic [7:0] CODE_NONE       = 8'h00;
   localparam logic [7:0] CODE_BRK_COMM   = 8'h03;
   localparam logic [7:0] CODE_INT_COMM   = 8'h14;
   localparam logic [7:0] CODE_SW_TIMEOUT = 8'h15;
   localparam logic [7:0] CODE_WARN       = 8'h19;
   localparam logic [7:0] CODE_FAULT      = 8'h1a;

   // ------------------------------------------------------------------
   // selector switch field and profiles
   // ------------------------------------------------------------------
   localparam logic [1:0]  SW_UNDEF     = 2'h0;
   localparam logic [1:0]  SW_POS_ON    = 2'h1;
   localparam logic [1:0]  SW_POS_OFF   = 2'h2;
   localparam logic [1:0]  SW_POS_AUTO  = 2'h3;
   localparam logic [15:0] BASIC_MASK   = 16'h000e;
   localparam logic [15:0] ENABLE_MASK  = 16'h0470;
   localparam logic [15:0] DRIVE_MASK   = 16'h0b80;
   localparam logic [15:0] BRK_MASK     = 16'h03fe;
   localparam logic [15:0] FLTBIT_MASK  = 16'h0ff0;

   typedef enum logic [1:0] {
      SSDL_CL_NONE   = 2'h0,
      SSDL_CL_BASIC  = 2'h1,
      SSDL_CL_ENABLE = 2'h2,
      SSDL_CL_DRIVE  = 2'h3
   } ssdl_class_t;

   typedef enum logic [2:0] {
      SSDL_SW_OK      = 3'h1,
      SSDL_SW_WAIT    = 3'h2,
      SSDL_SW_TIMEOUT = 3'h4
   } ssdl_sw_state_t;

   // eight drive control bits of the cyclic output image
   typedef struct packed {
      logic run_command;
      logic coast_stop_inhibit;
      logic quick_stop_inhibit;
      logic operation_enable;
      logic ramp_enable;
      logic ramp_unfreeze;
      logic setpoint_enable;
      logic controller_has_control;
   } ssdl_drive_ctrl_t;

   // diagnostic part of the cyclic input image
   typedef struct packed {
      logic       diag;
      logic       fault;
      logic       warn;
      logic [1:0] switch_position_field;
   } ssdl_image_t;

   // profile independent diagnostics for the acyclic channel
   typedef struct packed {
      logic fault_pending;
      logic fault_cause;
      logic warn_pending;
      logic int_comm_err;
      logic sw_timeout;
   } ssdl_acyc_t;

endpackage

`default_nettype wire

// ===== rtl/ssdl_top.sv
// ssdl_top: diagnostic status logic of a networked motor soft starter.
// assumes gateway control and cause inputs are on MCLK; only the
// selector switch contacts come from a pin and are synchronised here.
`default_nettype none

module ssdl_top #(
   parameter int SW_TIMEOUT_CYCLES = ssdl_pkg::SW_TIMEOUT_CYC,
   parameter int SLOW_HALF_CYCLES  = ssdl_pkg::SLOW_HALF_CYC,
   parameter int FAST_HALF_CYCLES  = ssdl_pkg::FAST_HALF_CYC
) (
   input  wire logic                       MCLK,
   input  wire logic                       RST_N,
   input  wire logic [3:0]                 PROFILE,
   input  wire logic [1:0]                 SWITCH_PIN,
   input  wire ssdl_pkg::ssdl_drive_ctrl_t DRIVE_CTRL,
   input  wire logic                       FAULT_ACKNOWLEDGE,
   input  wire logic                       STARTER_FAULT,
   input  wire logic                       STARTER_WARN,
   input  wire logic                       INT_COMM_ERR,
   input  wire logic                       BRK_COMM_LOST,
   input  wire logic                       GW_NOT_READY,
   output ssdl_pkg::ssdl_image_t           IN_IMAGE,
   output logic [7:0]                      ADV_CODE,
   output ssdl_pkg::ssdl_acyc_t            ACYC_DIAG,
   output logic                            RUN_PERMIT,
   output logic                            OVERLOAD_EFFECTIVE,
   output logic                            LED_GREEN,
   output logic                            LED_ORANGE
);

   localparam int CW = ssdl_pkg::CNT_W;

   // ------------------------------------------------------------------
   // helper functions
   // ------------------------------------------------------------------

   // profile number to control group; unknown profiles map to none
   function automatic ssdl_pkg::ssdl_class_t prof_class(
      input logic [3:0] p);
      ssdl_pkg::ssdl_class_t c;
      c = ssdl_pkg::SSDL_CL_NONE;
      if (ssdl_pkg::BASIC_MASK[p])
         c = ssdl_pkg::SSDL_CL_BASIC;
      else if (ssdl_pkg::ENABLE_MASK[p])
         c = ssdl_pkg::SSDL_CL_ENABLE;
      else if (ssdl_pkg::DRIVE_MASK[p])
         c = ssdl_pkg::SSDL_CL_DRIVE;
      return c;
   endfunction

   // half-period counter step, shared by both flash generators
   function automatic logic [CW-1:0] cnt_step(
      input logic [CW-1:0] c,
      input int            half);
      logic [CW-1:0] n;
      n = '0;
      if (c < CW'(half - 1))
         n = c + CW'(1);
      return n;
   endfunction

   // ------------------------------------------------------------------
   // selector switch synchroniser
   // ------------------------------------------------------------------
   logic [1:0] sw_meta;
   logic [1:0] sw_pos;

   // the first stage is read only by the second stage
   always_ff @(posedge MCLK or negedge RST_N) begin
      if (!RST_N) begin
         sw_meta <= ssdl_pkg::SW_UNDEF;
         sw_pos  <= ssdl_pkg::SW_UNDEF;
      end else begin
         sw_meta <= SWITCH_PIN;
         sw_pos  <= sw_meta;
      end
   end

   // ------------------------------------------------------------------
   // switch watchdog
   // ------------------------------------------------------------------
   ssdl_pkg::ssdl_sw_state_t sw_state;
   ssdl_pkg::ssdl_sw_state_t next_sw_state;
   logic [CW-1:0]            sw_cnt;
   logic                     sw_undef;
   logic                     sw_timeout;

   assign sw_undef   = (sw_pos == ssdl_pkg::SW_UNDEF);
   assign sw_timeout = (sw_state == ssdl_pkg::SSDL_SW_TIMEOUT);

   // wait more than the timeout, leave only on a defined position
   always_comb begin
      next_sw_state = sw_state;
      unique case (sw_state)
         ssdl_pkg::SSDL_SW_OK: begin
            if (sw_undef)
               next_sw_state = ssdl_pkg::SSDL_SW_WAIT;
         end
         ssdl_pkg::SSDL_SW_WAIT: begin
            if (!sw_undef)
               next_sw_state = ssdl_pkg::SSDL_SW_OK;
            else if (sw_cnt == CW'(SW_TIMEOUT_CYCLES))
               next_sw_state = ssdl_pkg::SSDL_SW_TIMEOUT;
         end
         ssdl_pkg::SSDL_SW_TIMEOUT: begin
            if (!sw_undef)
               next_sw_state = ssdl_pkg::SSDL_SW_OK;
         end
         default: next_sw_state = ssdl_pkg::SSDL_SW_OK;
      endcase
   end

   always_ff @(posedge MCLK or negedge RST_N) begin
      if (!RST_N)
         sw_state <= ssdl_pkg::SSDL_SW_OK;
      else
         sw_state <= next_sw_state;
   end

   // time spent in the wait state, reloaded with 1 whenever the watchdog is not waiting
   always_ff @(posedge MCLK or negedge RST_N) begin
      if (!RST_N)
         sw_cnt <= '0;
      else if (sw_state != ssdl_pkg::SSDL_SW_WAIT)
         sw_cnt <= CW'(1);
      else if (sw_cnt != CW'(SW_TIMEOUT_CYCLES))
         sw_cnt <= sw_cnt + CW'(1);
   end

   // ------------------------------------------------------------------
   // flash pattern generators
   // ------------------------------------------------------------------
   logic [CW-1:0] slow_cnt;
   logic [CW-1:0] fast_cnt;
   logic          slow_ph;
   logic          fast_ph;

   // free running so every indicator using a rate flashes in step
   always_ff @(posedge MCLK or negedge RST_N) begin
      if (!RST_N) begin
         slow_cnt <= '0;
         slow_ph  <= 1'b1;
      end else begin
         slow_cnt <= cnt_step(slow_cnt, SLOW_HALF_CYCLES);
         if (slow_cnt == CW'(SLOW_HALF_CYCLES - 1))
            slow_ph <= !slow_ph;
      end
   end

   always_ff @(posedge MCLK or negedge RST_N) begin
      if (!RST_N) begin
         fast_cnt <= '0;
         fast_ph  <= 1'b1;
      end else begin
         fast_cnt <= cnt_step(fast_cnt, FAST_HALF_CYCLES);
         if (fast_cnt == CW'(FAST_HALF_CYCLES - 1))
            fast_ph <= !fast_ph;
      end
   end

   // ------------------------------------------------------------------
   // profile decode and switching command
   // ------------------------------------------------------------------
   ssdl_pkg::ssdl_class_t cls;
   logic                  sw_cmd;
   logic                  brk_allowed;
   logic                  fault_bit_used;

   assign cls            = prof_class(PROFILE);
   assign brk_allowed    = ssdl_pkg::BRK_MASK[PROFILE];
   assign fault_bit_used = ssdl_pkg::FLTBIT_MASK[PROFILE];

   always_comb begin
      sw_cmd = 1'b0;
      unique case (cls)
         ssdl_pkg::SSDL_CL_BASIC:
            sw_cmd = DRIVE_CTRL.run_command;
         ssdl_pkg::SSDL_CL_ENABLE:
            sw_cmd = DRIVE_CTRL.setpoint_enable &
                     DRIVE_CTRL.operation_enable;
         ssdl_pkg::SSDL_CL_DRIVE:
            sw_cmd = &DRIVE_CTRL;
         ssdl_pkg::SSDL_CL_NONE:
            sw_cmd = 1'b0;
      endcase
   end

   // ------------------------------------------------------------------
   // fault latch and acknowledge
   // ------------------------------------------------------------------
   logic run_prev;
   logic fault_latch;
   logic fault_cause;
   logic ack_req;

   // cause is live until both the starter fault and timeout are gone
   assign fault_cause = STARTER_FAULT | sw_timeout;

   always_comb begin
      ack_req = (sw_pos == ssdl_pkg::SW_POS_OFF);
      if (cls == ssdl_pkg::SSDL_CL_BASIC)
         ack_req = ack_req |
                   (run_prev & !DRIVE_CTRL.run_command);
      else if (cls != ssdl_pkg::SSDL_CL_NONE)
         ack_req = ack_req | FAULT_ACKNOWLEDGE;
   end

   always_ff @(posedge MCLK or negedge RST_N) begin
      if (!RST_N)
         run_prev <= 1'b0;
      else
         run_prev <= DRIVE_CTRL.run_command;
   end

   // set wins: an acknowledge while the cause stands is ignored
   always_ff @(posedge MCLK or negedge RST_N) begin
      if (!RST_N)
         fault_latch <= 1'b0;
      else if (fault_cause)
         fault_latch <= 1'b1;
      else if (ack_req)
         fault_latch <= 1'b0;
   end

   // ------------------------------------------------------------------
   // diagnostic selection
   // ------------------------------------------------------------------
   logic       diag_now;
   logic [7:0] next_code;
   logic       brk_diag;

   assign brk_diag = BRK_COMM_LOST & brk_allowed;

   // most severe cause wins when several are pending at once
   always_comb begin
      next_code = ssdl_pkg::CODE_NONE;
      if (sw_timeout)
         next_code = ssdl_pkg::CODE_SW_TIMEOUT;
      else if (INT_COMM_ERR)
         next_code = ssdl_pkg::CODE_INT_COMM;
      else if (fault_latch)
         next_code = ssdl_pkg::CODE_FAULT;
      else if (STARTER_WARN)
         next_code = ssdl_pkg::CODE_WARN;
      else if (brk_diag)
         next_code = ssdl_pkg::CODE_BRK_COMM;
   end

   // the flag is raised exactly when a code is on offer
   assign diag_now = (next_code != ssdl_pkg::CODE_NONE);

   // ------------------------------------------------------------------
   // cyclic image, code and acyclic registers
   // ------------------------------------------------------------------
   always_ff @(posedge MCLK or negedge RST_N) begin
      if (!RST_N) begin
         IN_IMAGE <= '0;
         ADV_CODE <= ssdl_pkg::CODE_NONE;
      end else begin
         IN_IMAGE.diag  <= diag_now;
         IN_IMAGE.fault <= fault_latch & fault_bit_used;
         // warning mirrors the cause only in profiles 4 to 11, nothing latches or reacts
         IN_IMAGE.warn  <= STARTER_WARN & fault_bit_used;
         IN_IMAGE.switch_position_field <= sw_pos;
         ADV_CODE <= next_code;
      end
   end

   // profile independent view for the parameter channel
   always_ff @(posedge MCLK or negedge RST_N) begin
      if (!RST_N)
         ACYC_DIAG <= '0;
      else begin
         ACYC_DIAG.fault_pending <= fault_latch;
         ACYC_DIAG.fault_cause   <= fault_cause;
         ACYC_DIAG.warn_pending  <= STARTER_WARN;
         ACYC_DIAG.int_comm_err  <= INT_COMM_ERR;
         ACYC_DIAG.sw_timeout    <= sw_timeout;
      end
   end

   // ------------------------------------------------------------------
   // starter reaction
   // ------------------------------------------------------------------
   // a breaker link loss keeps the starter running; only the overload
   // trip function loses effect since the breaker isolates on its own
   always_ff @(posedge MCLK or negedge RST_N) begin
      if (!RST_N) begin
         RUN_PERMIT         <= 1'b0;
         OVERLOAD_EFFECTIVE <= 1'b0;
      end else begin
         RUN_PERMIT         <= !fault_latch & !fault_cause;
         OVERLOAD_EFFECTIVE <= !BRK_COMM_LOST;
      end
   end

   // ------------------------------------------------------------------
   // diagnostic led
   // ------------------------------------------------------------------
   logic next_green;
   logic next_orange;

   always_comb begin
      next_green  = 1'b0;
      next_orange = 1'b0;
      if (sw_timeout)
         next_green = fast_ph;
      else if (sw_cmd && sw_pos == ssdl_pkg::SW_POS_AUTO)
         next_orange = diag_now ? fast_ph : 1'b1;
      else if (diag_now)
         next_green = fast_ph;
      else if (GW_NOT_READY)
         next_green = slow_ph;
      else
         next_green = 1'b1;
   end

   // registered so the pins never glitch on input changes
   always_ff @(posedge MCLK or negedge RST_N) begin
      if (!RST_N) begin
         LED_GREEN  <= 1'b0;
         LED_ORANGE <= 1'b0;
      end else begin
         LED_GREEN  <= next_green;
         LED_ORANGE <= next_orange;
      end
   end

endmodule // ssdl_top

`default_nettype wire

// ===== tb/ssdl_gw_model.sv
// ssdl_gw_model: gateway side that writes the cyclic control image.
// assumes the bench calls put; values change just after a clock edge.
`default_nettype none

module ssdl_gw_model (
   input  wire logic                       mclk,
   output var logic [3:0]                  profile,
   output var ssdl_pkg::ssdl_drive_ctrl_t  drive_ctrl,
   output var logic                        fault_acknowledge,
   output var logic                        gw_not_ready
);
   timeunit 1ns;
   timeprecision 1ns;

   // idle image at power-up: profile 5, no command, no ack
   initial begin
      profile = 4'h5;
      drive_ctrl = 8'h00;
      fault_acknowledge = 1'b0;
      gw_not_ready = 1'b0;
   end

   // one cyclic frame; the caller acks only after the cause is gone
   task automatic put(input logic [3:0] p, input logic [7:0] c,
                      input logic a, input logic n);
      @(posedge mclk);
      profile <= p;
      drive_ctrl <= c;
      fault_acknowledge <= a;
      gw_not_ready <= n;
   endtask
endmodule // ssdl_gw_model

`default_nettype wire

// ===== tb/ssdl_top_assertions.sv
// ssdl_top_assertions: port-level checks of the diagnostic status logic.
// assumes it is bound onto ssdl_top; every port lives on MCLK.
`default_nettype none

module ssdl_top_assertions #(
   parameter int SW_TIMEOUT_CYCLES = 40
) (
   input wire logic                  MCLK,
   input wire logic                  RST_N,
   input wire logic [3:0]            PROFILE,
   input wire logic [1:0]            SWITCH_PIN,
   input wire logic                  STARTER_FAULT,
   input wire logic                  STARTER_WARN,
   input wire logic                  INT_COMM_ERR,
   input wire logic                  BRK_COMM_LOST,
   input wire ssdl_pkg::ssdl_image_t IN_IMAGE,
   input wire logic [7:0]            ADV_CODE,
   input wire logic                  RUN_PERMIT,
   input wire logic                  OVERLOAD_EFFECTIVE
);
   timeunit 1ns;
   timeprecision 1ns;

   default clocking @(posedge MCLK); endclocking
   default disable iff (!RST_N);

   // ---
   // helper: length of the current undefined selector stretch
   // ---
   int undef_run;

   // saturates so a parked switch never wraps the count
   always_ff @(posedge MCLK or negedge RST_N) begin
      if (!RST_N) undef_run <= 0;
      else if (SWITCH_PIN != 2'h0) undef_run <= 0;
      else if (undef_run < 100000) undef_run <= undef_run + 1;
   end

   // ---
   // sequences and properties
   // ---
   sequence s_cause_held;
      STARTER_FAULT [*2];
   endsequence
   // raw pin needs three edges to reach the field
   sequence s_undef_held;
      (SWITCH_PIN == 2'h0) [*4];
   endsequence

   AST_DIAG_CODE: assert property (
      IN_IMAGE.diag == (ADV_CODE != 8'h00)) else $error("diag flag vs code");
   AST_BRK_PROFILE: assert property (
      ADV_CODE == 8'h03 |-> $past(BRK_COMM_LOST)
         && $past(PROFILE) inside {[4'h1:4'h9]}) else $error("code 03");
   AST_INT_COMM: assert property (
      INT_COMM_ERR |=> ADV_CODE inside {8'h14, 8'h15})
      else $error("internal comm code missing");
   AST_WARN_BIT: assert property (
      IN_IMAGE.warn |-> $past(STARTER_WARN)
         && $past(PROFILE) inside {[4'h4:4'hb]}) else $error("warn bit");
   AST_OVERLOAD: assert property (
      BRK_COMM_LOST |=> !OVERLOAD_EFFECTIVE) else $error("overload kept");
   AST_TIMEOUT_STOP: assert property (
      ADV_CODE == 8'h15 |=> !RUN_PERMIT) else $error("run after timeout");
   AST_FAULT_CODE: assert property (
      s_cause_held |=> ADV_CODE inside {8'h14, 8'h15, 8'h1a})
      else $error("fault code missing");
   AST_SW_FIELD: assert property (
      s_undef_held |-> IN_IMAGE.switch_position_field == 2'h0)
      else $error("field not 00");
   AST_TIMEOUT_MIN: assert property (
      $rose(ADV_CODE == 8'h15) |-> undef_run >= SW_TIMEOUT_CYCLES)
      else $error("timeout too early");
   AST_TIMEOUT_MAX: assert property (
      undef_run == SW_TIMEOUT_CYCLES + 8 |-> ADV_CODE == 8'h15)
      else $error("timeout too late");
endmodule // ssdl_top_assertions

bind ssdl_top ssdl_top_assertions #(
   .SW_TIMEOUT_CYCLES(SW_TIMEOUT_CYCLES)
) i_chk (
   .MCLK(MCLK), .RST_N(RST_N), .PROFILE(PROFILE), .SWITCH_PIN(SWITCH_PIN),
   .STARTER_FAULT(STARTER_FAULT), .STARTER_WARN(STARTER_WARN),
   .INT_COMM_ERR(INT_COMM_ERR), .BRK_COMM_LOST(BRK_COMM_LOST),
   .IN_IMAGE(IN_IMAGE), .ADV_CODE(ADV_CODE), .RUN_PERMIT(RUN_PERMIT),
   .OVERLOAD_EFFECTIVE(OVERLOAD_EFFECTIVE)
);

`default_nettype wire

// ===== tb/starter_diagnostic_status_logic_tb.sv
// starter_diagnostic_status_logic_tb: directed bench for ssdl_top.
// assumes shortened counts: timeout 40, flash half periods 10 and 4.
`default_nettype none

module starter_diagnostic_status_logic_tb;
   timeunit 1ns;
   timeprecision 1ns;
   localparam int SWT = 40;
   localparam int SLOW = 10;
   localparam int FAST = 4;

   logic mclk = 1'b0;
   logic rst_n = 1'b0;
   logic [1:0] sw = 2'h1;
   logic [3:0] cs = 4'h0; // fault, warn, internal comm, breaker link
   logic [3:0] prof;
   logic [7:0] code;
   logic ack, nrdy, run_ok, ovl, led_g, led_o;
   ssdl_pkg::ssdl_drive_ctrl_t ctrl;
   ssdl_pkg::ssdl_image_t img;
   ssdl_pkg::ssdl_acyc_t acyc;
   int failures = 0;
   int comparisons = 0;

   always #50 mclk = ~mclk;

   ssdl_gw_model i_gw (.mclk(mclk), .profile(prof), .drive_ctrl(ctrl),
      .fault_acknowledge(ack), .gw_not_ready(nrdy));
   ssdl_top #(.SW_TIMEOUT_CYCLES(SWT), .SLOW_HALF_CYCLES(SLOW),
      .FAST_HALF_CYCLES(FAST)) i_dut (.MCLK(mclk), .RST_N(rst_n),
      .PROFILE(prof), .SWITCH_PIN(sw), .DRIVE_CTRL(ctrl),
      .FAULT_ACKNOWLEDGE(ack), .STARTER_FAULT(cs[3]), .STARTER_WARN(cs[2]),
      .INT_COMM_ERR(cs[1]), .BRK_COMM_LOST(cs[0]), .GW_NOT_READY(nrdy),
      .IN_IMAGE(img), .ADV_CODE(code), .ACYC_DIAG(acyc),
      .RUN_PERMIT(run_ok), .OVERLOAD_EFFECTIVE(ovl), .LED_GREEN(led_g),
      .LED_ORANGE(led_o));

   // ---
   // compare and drive tasks
   // ---
   task automatic miss(input string m);
      failures++;
      $display("ERROR %0t %s", $time, m);
   endtask
   task automatic chk_code(input logic [7:0] g, input logic [7:0] e);
      comparisons++;
      if (g !== e) miss($sformatf("code %h want %h", g, e));
   endtask
   task automatic chk_bit(input logic g, input logic e, input string n);
      comparisons++;
      if (g !== e) miss({n, " wrong"});
   endtask
   task automatic chk_half(input int g, input int e);
      comparisons++;
      if (g != e) miss($sformatf("flash half %0d want %0d", g, e));
   endtask
   // sample half a cycle after the edge so outputs have settled
   task automatic tick(input int n);
      repeat (n) @(posedge mclk);
      @(negedge mclk);
   endtask
   task automatic cause(input logic [3:0] v);
      @(posedge mclk);
      cs <= v;
   endtask
   task automatic pin(input logic [1:0] v);
      @(posedge mclk);
      sw <= v;
   endtask
   // second run between changes is a full half period; steady hits 40
   task automatic flash(input logic g, input int e);
      logic v;
      int n;
      @(negedge mclk);
      repeat (2) begin
         v = g ? led_g : led_o;
         n = 0;
         while ((g ? led_g : led_o) === v && n < 40) begin
            @(negedge mclk);
            n++;
         end
      end
      chk_half(n, e);
   endtask
   // shortest control word that counts as a switching command
   function automatic logic [7:0] cmd(input int p, input logic full);
      if (p < 4) return full ? 8'h80 : 8'h7f;
      if (p inside {4, 5, 6, 10}) return full ? 8'h12 : 8'h02;
      return full ? 8'hff : 8'hfe;
   endfunction
   task automatic results();
      if (failures == 0 && comparisons > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask

   // ---
   // main sequence
   // ---
   initial begin
      repeat (20) @(posedge mclk);
      rst_n <= 1'b1;
      tick(4);
      chk_code(code, 8'h00);
      chk_bit(ovl, 1'b1, "overload");
      chk_bit(led_g, 1'b1, "green");
      for (int p = 1; p < 4; p++) begin
         pin(p[1:0]);
         tick(4);
         chk_bit(img.switch_position_field === p[1:0], 1'b1, "field");
      end
      // selector now in auto: orange only with a full command
      for (int p = 1; p < 12; p++) begin
         i_gw.put(p[3:0], cmd(p, 1'b1), 1'b0, 1'b0);
         tick(3);
         chk_bit(led_o, 1'b1, "orange");
         chk_bit(led_g, 1'b0, "green");
         i_gw.put(p[3:0], cmd(p, 1'b0), 1'b0, 1'b0);
         tick(3);
         chk_bit(led_o, 1'b0, "orange");
      end
      // profile outside every group never counts as a command
      i_gw.put(4'h0, 8'hff, 1'b0, 1'b0);
      tick(3);
      chk_bit(led_o, 1'b0, "orange");
      i_gw.put(4'h9, 8'hff, 1'b0, 1'b0);
      cause(4'h1);
      tick(3);
      chk_code(code, 8'h03);
      chk_bit(ovl, 1'b0, "overload");
      chk_bit(run_ok, 1'b1, "run");
      flash(1'b0, FAST);
      i_gw.put(4'ha, 8'h12, 1'b0, 1'b0);
      tick(3);
      chk_code(code, 8'h00);
      chk_bit(led_o, 1'b1, "orange");
      i_gw.put(4'ha, 8'h00, 1'b0, 1'b0);
      cause(4'h4);
      tick(3);
      chk_code(code, 8'h19);
      chk_bit(img.warn, 1'b1, "warn");
      chk_bit(img.diag, 1'b1, "diag");
      chk_bit(ovl, 1'b1, "overload");
      flash(1'b1, FAST);
      i_gw.put(4'h5, 8'h00, 1'b1, 1'b0);
      tick(3);
      chk_code(code, 8'h19);
      chk_bit(run_ok, 1'b1, "run");
      i_gw.put(4'h2, 8'h00, 1'b0, 1'b0);
      tick(3);
      chk_bit(img.warn, 1'b0, "warn");
      chk_bit(acyc.warn_pending, 1'b1, "acyc warn");
      cause(4'h6);
      tick(3);
      chk_code(code, 8'h14);
      chk_bit(acyc.int_comm_err, 1'b1, "acyc comm");
      cause(4'h0);
      i_gw.put(4'h2, 8'h00, 1'b0, 1'b1);
      tick(3);
      chk_code(code, 8'h00);
      flash(1'b1, SLOW);
      // fault in profile 2: the start/stop fall clears it, the acknowledge bit does not
      pin(2'h1);
      i_gw.put(4'h2, 8'h80, 1'b0, 1'b0);
      cause(4'h8);
      tick(3);
      chk_code(code, 8'h1a);
      chk_bit(run_ok, 1'b0, "run");
      chk_bit(img.fault, 1'b0, "fault");
      chk_bit(acyc.fault_pending, 1'b1, "acyc fault");
      chk_bit(acyc.fault_cause, 1'b1, "acyc cause");
      i_gw.put(4'h2, 8'h00, 1'b0, 1'b0);
      tick(3);
      chk_code(code, 8'h1a);
      cause(4'h0);
      i_gw.put(4'h2, 8'h00, 1'b1, 1'b0);
      tick(3);
      chk_code(code, 8'h1a);
      i_gw.put(4'h2, 8'h80, 1'b0, 1'b0);
      i_gw.put(4'h2, 8'h00, 1'b0, 1'b0);
      tick(4);
      chk_code(code, 8'h00);
      chk_bit(run_ok, 1'b1, "run");
      // fault in profile 5: acknowledge bit, not the command fall
      i_gw.put(4'h5, 8'h80, 1'b0, 1'b0);
      cause(4'h8);
      tick(3);
      chk_bit(img.fault, 1'b1, "fault");
      cause(4'h0);
      i_gw.put(4'h5, 8'h00, 1'b0, 1'b0);
      tick(3);
      chk_code(code, 8'h1a);
      i_gw.put(4'h5, 8'h00, 1'b1, 1'b0);
      tick(4);
      chk_code(code, 8'h00);
      i_gw.put(4'h6, 8'h00, 1'b0, 1'b0);
      // undefined selector: quiet before the limit, alarm after it
      pin(2'h0);
      tick(30);
      chk_code(code, 8'h00);
      tick(20);
      chk_code(code, 8'h15);
      chk_bit(img.fault, 1'b1, "fault");
      chk_bit(img.diag, 1'b1, "diag");
      chk_bit(run_ok, 1'b0, "run");
      chk_bit(acyc.sw_timeout, 1'b1, "acyc timeout");
      chk_bit(img.switch_position_field === 2'h0, 1'b1, "field");
      flash(1'b1, FAST);
      pin(2'h1);
      tick(6);
      chk_code(code, 8'h1a);
      pin(2'h2);
      tick(6);
      chk_code(code, 8'h00);
      chk_bit(run_ok, 1'b1, "run");
      // second reset in mid-run clears outputs and counters
      @(posedge mclk);
      rst_n <= 1'b0;
      tick(2);
      chk_code(code, 8'h00);
      chk_bit(led_g, 1'b0, "green");
      @(posedge mclk);
      rst_n <= 1'b1;
      tick(4);
      chk_bit(led_g, 1'b1, "green");
      results();
   end
endmodule // starter_diagnostic_status_logic_tb

`default_nettype wire
